// file: hw/sync_rx_pkg.sv
// types of the receive framing block
`default_nettype none
package sync_rx_pkg;

  typedef enum logic [1:0] {st_idle, st_wait, st_delay, st_data} rx_state_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [11:0] divider;
    logic [31:0] rx_clock_mode;
    logic [31:0] rx_frame_mode;
    logic [31:0] tx_clock_mode;
    logic [15:0] compare0;
    logic [15:0] compare1;
    logic [31:0] rx_holding;
    logic [15:0] rx_sync_holding;
    logic rx_en;
    logic dis_pend;
    logic stop_pend;
    logic rx_ready;
    logic sync_event;
    logic cmp0_flag;
    logic cmp1_flag;
    logic a_sel;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [11:0] div_cnt;
    logic div_clk;
    logic rxck_prev;
    logic rf_prev;
    rx_state_t st;
    logic [7:0] dly_cnt;
    logic [4:0] bit_cnt;
    logic [3:0] word_cnt;
    logic [31:0] word;
    logic [15:0] sync_sh;
    logic [15:0] cmp_sh;
    logic cont;
    logic [8:0] per_cnt;
    logic [8:0] fs_cnt;
    logic toggle;
    logic rf_out;
    logic rf_oe;
    logic tx_clk;
    logic [1:0] dma_size;
  } rx_regs_t;

endpackage : sync_rx_pkg
`default_nettype wire

// file: hw/sync_rx_regs.svh
// register offsets, field positions and reset values for the receive framing block
`ifndef SYNC_RX_REGS_SVH
`define SYNC_RX_REGS_SVH

// byte offsets on the register bus
`define OFS_CONTROL 8'h00
`define OFS_CLOCK_MODE 8'h04
`define OFS_RX_CLOCK_MODE 8'h10
`define OFS_RX_FRAME_MODE 8'h14
`define OFS_TX_CLOCK_MODE 8'h18
`define OFS_RX_HOLDING 8'h20
`define OFS_RX_SYNC_HOLDING 8'h30
`define OFS_RX_COMPARE0 8'h38
`define OFS_RX_COMPARE1 8'h3C
`define OFS_STATUS 8'h40

// control register bits
`define CTL_RX_ENABLE 0
`define CTL_RX_DISABLE 1
`define CTL_SOFT_RESET 15

// receive clock mode fields
`define RCM_SOURCE 1:0
`define RCM_INVERT 5
`define RCM_GATING 7:6
`define RCM_START 11:8
`define RCM_STOP 12
`define RCM_DELAY 23:16
`define RCM_PERIOD 31:24

// receive frame mode fields
`define RFM_WORD_LEN 4:0
`define RFM_LOOP 5
`define RFM_HIGH_FIRST 7
`define RFM_WORDS 11:8
`define RFM_SYNC_LEN 19:16
`define RFM_SHAPE 22:20
`define RFM_EDGE 24
`define RFM_SYNC_UPPER 31:28

// status bits
`define STS_RX_READY 0
`define STS_COMPARE0 1
`define STS_COMPARE1 2
`define STS_SYNC_EVENT 3
`define STS_RX_ENABLED 4

`define RESET_WORD 32'h00000000
`define RESET_DIVIDER 12'h000

`endif

// file: hw/sync_serial_receive_framing.sv
// receive clock and frame control of the synchronous serial controller, with its register slave
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`default_nettype none
`include "sync_rx_regs.svh"

module sync_serial_receive_framing (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins
  input wire logic receive_clock_pin,
  input wire logic receive_frame_sync_pin_in,
  output logic receive_frame_sync_pin_out,
  output logic receive_frame_sync_pin_oe,
  input wire logic rx_data_pin,
  input wire logic transmit_clock_pin,
  input wire logic transmit_frame_sync_pin,
  input wire logic transmit_data_pin,
  // transmitter side and receive DMA size, same clock
  input wire logic transmit_start,
  output logic transmit_clock_selected,
  output logic [1:0] dma_transfer_size
);

  sync_rx_pkg::rx_regs_t cur;
  sync_rx_pkg::rx_regs_t next_cur;

  logic loop_on;
  logic rf_lvl;
  logic rd_lvl;
  logic src_ck;
  logic gated_ck;
  logic ck_rise;
  logic ck_fall;
  logic sample;
  logic drive;
  logic rf_rise;
  logic rf_fall;
  logic [15:0] cmp_mask;
  logic cmp0_hit;
  logic cmp1_hit;
  logic per_evt;
  logic start_evt;
  logic frame_start;
  logic fs_pulse;
  logic bus_take;
  logic [3:0] start_code;
  logic [3:0] sync_len;
  logic [4:0] word_len;

  assign hreadyout = cur.hreadyout;
  assign hresp = cur.hresp;
  assign hrdata = cur.hrdata;
  assign receive_frame_sync_pin_out = cur.rf_out;
  assign receive_frame_sync_pin_oe = cur.rf_oe;
  assign transmit_clock_selected = cur.tx_clk;
  assign dma_transfer_size = cur.dma_size;

  always_comb begin
    next_cur = cur;
    loop_on = cur.rx_frame_mode[`RFM_LOOP];
    start_code = cur.rx_clock_mode[`RCM_START];
    sync_len = cur.rx_frame_mode[`RFM_SYNC_LEN];
    word_len = cur.rx_frame_mode[`RFM_WORD_LEN];
    // pins pass two flops; only the second stage is read below
    next_cur.sync1 = {transmit_data_pin, transmit_frame_sync_pin, transmit_clock_pin,
                      rx_data_pin, receive_frame_sync_pin_in, receive_clock_pin};
    next_cur.sync2 = cur.sync1;

    // divided clock, toggles every divider cycles
    if (cur.divider == 12'h000) begin
      next_cur.div_cnt = 12'h000;
      next_cur.div_clk = 1'b0;
    end else if (cur.div_cnt >= cur.divider - 12'h001) begin
      next_cur.div_cnt = 12'h000;
      next_cur.div_clk = ~cur.div_clk;
    end else begin
      next_cur.div_cnt = cur.div_cnt + 12'h001;
    end

    // in loopback the pin is ignored and the transmit frame sync is seen instead
    rf_lvl = loop_on ? cur.sync2[4] : (cur.rf_oe ? cur.rf_out : cur.sync2[1]);
    rd_lvl = loop_on ? cur.sync2[5] : cur.sync2[2];
    case (cur.rx_clock_mode[`RCM_SOURCE])
      2'h0: src_ck = cur.div_clk;
      2'h1: src_ck = cur.sync2[3];
      2'h2: src_ck = cur.sync2[0];
      default: src_ck = 1'b0;
    endcase
    if (loop_on) begin
      src_ck = cur.sync2[3];
    end
    case (cur.rx_clock_mode[`RCM_GATING])
      2'h0: gated_ck = src_ck;
      2'h1: gated_ck = src_ck & ~rf_lvl;
      2'h2: gated_ck = src_ck & rf_lvl;
      default: gated_ck = 1'b0;
    endcase
    next_cur.rxck_prev = gated_ck;
    ck_rise = gated_ck & ~cur.rxck_prev;
    ck_fall = ~gated_ck & cur.rxck_prev;
    sample = cur.rx_clock_mode[`RCM_INVERT] ? ck_rise : ck_fall;
    drive = cur.rx_clock_mode[`RCM_INVERT] ? ck_fall : ck_rise;

    case (cur.tx_clock_mode[`RCM_SOURCE])
      2'h0: next_cur.tx_clk = cur.div_clk;
      2'h1: next_cur.tx_clk = src_ck;
      2'h2: next_cur.tx_clk = cur.sync2[3];
      default: next_cur.tx_clk = 1'b0;
    endcase

    if (word_len <= 5'h07) begin
      next_cur.dma_size = 2'h0;
    end else if (word_len <= 5'h0F) begin
      next_cur.dma_size = 2'h1;
    end else begin
      next_cur.dma_size = 2'h2;
    end

    // bus address phase; status clears go first so that a same-cycle set wins
    bus_take = hsel & hready & htrans[1];
    next_cur.a_sel = bus_take;
    next_cur.a_wr = hwrite;
    next_cur.a_addr = haddr[7:0];
    if (bus_take && !hwrite) begin
      case (haddr[7:0])
        `OFS_CLOCK_MODE: next_cur.hrdata = {20'h00000, cur.divider};
        `OFS_RX_CLOCK_MODE: next_cur.hrdata = cur.rx_clock_mode;
        `OFS_RX_FRAME_MODE: next_cur.hrdata = cur.rx_frame_mode;
        `OFS_TX_CLOCK_MODE: next_cur.hrdata = cur.tx_clock_mode;
        `OFS_RX_HOLDING: next_cur.hrdata = cur.rx_holding;
        `OFS_RX_SYNC_HOLDING: next_cur.hrdata = {16'h0000, cur.rx_sync_holding};
        `OFS_RX_COMPARE0: next_cur.hrdata = {16'h0000, cur.compare0};
        `OFS_RX_COMPARE1: next_cur.hrdata = {16'h0000, cur.compare1};
        `OFS_STATUS: next_cur.hrdata = {27'h0000000, cur.rx_en, cur.sync_event, cur.cmp1_flag,
                                        cur.cmp0_flag, cur.rx_ready};
        default: next_cur.hrdata = 32'h00000000;
      endcase
      if (haddr[7:0] == `OFS_RX_HOLDING) begin
        next_cur.rx_ready = 1'b0;
      end
      if (haddr[7:0] == `OFS_STATUS) begin
        next_cur.sync_event = 1'b0;
        next_cur.cmp0_flag = 1'b0;
        next_cur.cmp1_flag = 1'b0;
      end
    end

    // frame sync edges and compare shifter, all on sampling edges
    rf_rise = sample & rf_lvl & ~cur.rf_prev;
    rf_fall = sample & ~rf_lvl & cur.rf_prev;
    cmp_mask = (16'h0001 << sync_len) - 16'h0001;
    if (sample || cur.st == sync_rx_pkg::st_idle) begin // idle tracks the resting level, so no false first edge
      next_cur.rf_prev = rf_lvl;
    end
    if (sample) begin
      next_cur.cmp_sh = {cur.cmp_sh[14:0], rd_lvl};
    end
    cmp0_hit = sample && (sync_len != 4'h0) && ((next_cur.cmp_sh & cmp_mask) == (cur.compare0 & cmp_mask));
    cmp1_hit = sample && (sync_len != 4'h0) && ((next_cur.cmp_sh & cmp_mask) == (cur.compare1 & cmp_mask));
    if (cur.rx_frame_mode[`RFM_EDGE] ? rf_fall : rf_rise) begin
      next_cur.sync_event = 1'b1;
    end

    // period frame sync generator
    per_evt = 1'b0;
    if (cur.rx_clock_mode[`RCM_PERIOD] == 8'h00) begin
      next_cur.per_cnt = 9'h000;
    end else if (sample) begin
      if (cur.per_cnt >= {cur.rx_clock_mode[`RCM_PERIOD], 1'b1}) begin
        next_cur.per_cnt = 9'h000;
        per_evt = 1'b1;
      end else begin
        next_cur.per_cnt = cur.per_cnt + 9'h001;
      end
    end

    case (start_code)
      4'h0: start_evt = 1'b1;
      4'h1: start_evt = transmit_start;
      4'h2: start_evt = sample & ~rf_lvl;
      4'h3: start_evt = sample & rf_lvl;
      4'h4: start_evt = rf_fall;
      4'h5: start_evt = rf_rise;
      4'h6: start_evt = rf_rise | rf_fall;
      4'h7: start_evt = rf_rise | rf_fall;
      4'h8: start_evt = cmp0_hit;
      default: start_evt = 1'b0;
    endcase

    frame_start = 1'b0;
    case (cur.st)
      sync_rx_pkg::st_idle: begin
        next_cur.dis_pend = 1'b0;
        if (cur.rx_en) begin
          next_cur.st = sync_rx_pkg::st_wait;
        end
      end
      sync_rx_pkg::st_wait, sync_rx_pkg::st_delay: begin
        if (cur.dis_pend) begin
          next_cur.st = sync_rx_pkg::st_idle;
          next_cur.rx_en = 1'b0;
        end else if (cur.st == sync_rx_pkg::st_wait) begin
          if (start_evt) begin
            frame_start = 1'b1;
            if (start_code == 4'h8) begin
              next_cur.cmp0_flag = 1'b1;
            end
            next_cur.cont = (start_code == 4'h8) && cur.rx_clock_mode[`RCM_STOP];
            next_cur.stop_pend = 1'b0;
            next_cur.bit_cnt = 5'h00;
            next_cur.word_cnt = 4'h0;
            next_cur.word = 32'h00000000;
            next_cur.sync_sh = 16'h0000;
            next_cur.dly_cnt = cur.rx_clock_mode[`RCM_DELAY];
            // a transmitter-linked start takes the same delay path
            if (cur.rx_clock_mode[`RCM_DELAY] != 8'h00) begin
              next_cur.st = sync_rx_pkg::st_delay;
            end else begin
              next_cur.st = sync_rx_pkg::st_data;
            end
          end
        end else if (sample) begin
          // sync data is collected while the start delay runs
          next_cur.sync_sh = {cur.sync_sh[14:0], rd_lvl};
          if (cur.dly_cnt == 8'h01) begin
            next_cur.rx_sync_holding = {cur.sync_sh[14:0], rd_lvl} & cmp_mask;
            next_cur.st = sync_rx_pkg::st_data;
          end else begin
            next_cur.dly_cnt = cur.dly_cnt - 8'h01;
          end
        end
      end
      sync_rx_pkg::st_data: begin
        if (cur.cont && cmp1_hit) begin
          next_cur.stop_pend = 1'b1;
          next_cur.cmp1_flag = 1'b1;
        end
        if (sample) begin
          if (cur.rx_frame_mode[`RFM_HIGH_FIRST]) begin
            next_cur.word = {cur.word[30:0], rd_lvl};
          end else begin
            next_cur.word[cur.bit_cnt] = rd_lvl;
          end
          if (cur.bit_cnt >= word_len) begin
            next_cur.rx_holding = next_cur.word;
            next_cur.rx_ready = 1'b1;
            next_cur.bit_cnt = 5'h00;
            next_cur.word = 32'h00000000;
            next_cur.word_cnt = cur.word_cnt + 4'h1;
            // disabling waits for the end of the word in progress
            if (cur.dis_pend) begin
              next_cur.st = sync_rx_pkg::st_idle;
              next_cur.rx_en = 1'b0;
            end else if (cur.stop_pend || next_cur.stop_pend) begin
              next_cur.st = sync_rx_pkg::st_wait;
              next_cur.cont = 1'b0;
            end else if (cur.word_cnt >= cur.rx_frame_mode[`RFM_WORDS]) begin
              next_cur.word_cnt = 4'h0;
              if (!cur.cont) begin
                next_cur.st = sync_rx_pkg::st_wait;
              end
            end
          end else begin
            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
          end
        end
      end
      default: next_cur.st = sync_rx_pkg::st_idle;
    endcase

    // frame sync output; a running period replaces the per-transfer trigger
    if ((cur.rx_clock_mode[`RCM_PERIOD] != 8'h00) ? per_evt : frame_start) begin
      next_cur.fs_cnt = {5'h00, sync_len} + {1'b0, cur.rx_frame_mode[`RFM_SYNC_UPPER], 4'h0} + 9'h001;
    end else if (drive && cur.fs_cnt != 9'h000) begin
      next_cur.fs_cnt = cur.fs_cnt - 9'h001;
    end
    if (frame_start) begin
      next_cur.toggle = ~cur.toggle;
    end
    fs_pulse = cur.fs_cnt != 9'h000;
    next_cur.rf_oe = 1'b1;
    case (cur.rx_frame_mode[`RFM_SHAPE])
      3'h1: next_cur.rf_out = ~fs_pulse;
      3'h2: next_cur.rf_out = fs_pulse;
      3'h3: next_cur.rf_out = cur.st != sync_rx_pkg::st_data;
      3'h4: next_cur.rf_out = cur.st == sync_rx_pkg::st_data;
      3'h5: next_cur.rf_out = cur.toggle;
      default: begin
        next_cur.rf_out = 1'b0;
        next_cur.rf_oe = 1'b0;
      end
    endcase
    // the pin moves only on drive edges, so a pulse spans whole receive clock periods
    if (!drive && next_cur.rf_oe) begin
      next_cur.rf_out = cur.rf_out;
    end

    // bus data phase: writes land last and override the logic above
    if (cur.a_sel && cur.a_wr) begin
      case (cur.a_addr)
        `OFS_CONTROL: begin
          if (hwdata[`CTL_SOFT_RESET]) begin
            next_cur.divider = `RESET_DIVIDER;
            next_cur.rx_clock_mode = `RESET_WORD;
            next_cur.rx_frame_mode = `RESET_WORD;
            next_cur.tx_clock_mode = `RESET_WORD;
            next_cur.rx_en = 1'b0;
            next_cur.dis_pend = 1'b0;
            next_cur.st = sync_rx_pkg::st_idle;
          end else if (hwdata[`CTL_RX_DISABLE]) begin
            next_cur.dis_pend = 1'b1;
          end else if (hwdata[`CTL_RX_ENABLE]) begin
            next_cur.rx_en = 1'b1;
          end
        end
        `OFS_CLOCK_MODE: next_cur.divider = hwdata[11:0];
        `OFS_RX_CLOCK_MODE: next_cur.rx_clock_mode = hwdata;
        `OFS_RX_FRAME_MODE: next_cur.rx_frame_mode = hwdata;
        `OFS_TX_CLOCK_MODE: next_cur.tx_clock_mode = hwdata;
        `OFS_RX_COMPARE0: next_cur.compare0 = hwdata[15:0];
        `OFS_RX_COMPARE1: next_cur.compare1 = hwdata[15:0];
        default: next_cur.hrdata = cur.hrdata;
      endcase
    end
    next_cur.hreadyout = 1'b1;
    next_cur.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  a_shape_none_float: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.rx_frame_mode[22:20] == 3'h0 || cur.rx_frame_mode[22:20] >= 3'h6) |=> !receive_frame_sync_pin_oe)
    else $error("frame sync pin driven with shape none or reserved");
  a_divider_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.divider == 12'h000) |=> !cur.div_clk)
    else $error("divided clock runs with divider zero");
  a_divider_period: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(cur.div_clk) && cur.divider == 12'h002 && $stable(cur.divider)) |-> ##1 cur.div_clk ##1 !cur.div_clk)
    else $error("divided clock half period wrong for divider two");
  a_start_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.st == sync_rx_pkg::st_wait && cur.rx_clock_mode[11:8] >= 4'h9) |=> cur.st != sync_rx_pkg::st_data
      && cur.st != sync_rx_pkg::st_delay)
    else $error("reserved start code started reception");
  a_gating_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.rx_clock_mode[7:6] == 2'h3) |=> !cur.rxck_prev)
    else $error("receive clock runs with reserved gating");
  a_disabled_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.rx_en && !$past(cur.rx_en)) |-> cur.st == sync_rx_pkg::st_idle)
    else $error("receiver active while disabled");
  a_dma_byte: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.rx_frame_mode[4:0] <= 5'h07) |=> dma_transfer_size == 2'h0)
    else $error("dma size not byte for short words");
  a_delay_nonzero: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.st == sync_rx_pkg::st_wait ##1 cur.st == sync_rx_pkg::st_delay) |-> $past(cur.rx_clock_mode[23:16]) != 8'h00)
    else $error("delay state entered with zero start delay");

endmodule : sync_serial_receive_framing
`default_nettype wire

// file: verification/codec_model.sv
// behavioural serial codec sending one framed word on receive clock, frame sync and data
`default_nettype none
module codec_model (
  // control from the bench
  input wire logic go,
  input wire logic [7:0] value,
  input wire logic high_first,
  // serial pins
  output logic rk,
  output logic rf,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;
  initial begin
    rk = 1'b0;
    rf = 1'b1;
    rd = 1'b0;
  end
  // clock stands low outside frames; data changes on rising edge, device samples on falling
  always @(posedge go) begin
    rd = ~value[high_first ? 7 : 0];
    #200 rk = 1'b1;
    rf = 1'b0;
    #200 rk = 1'b0;
    for (i = 0; i < 8; i++) begin
      #200 rk = 1'b1;
      rd = value[high_first ? 7 - i : i];
      #200 rk = 1'b0;
    end
    #200 rk = 1'b1;
    rf = 1'b1;
    rd = ~rd;
    #200 rk = 1'b0;
  end
endmodule : codec_model
`default_nettype wire

// file: verification/sync_serial_receive_framing_test.sv
// self-checking bench of the receive framing block
`default_nettype none
`include "sync_rx_regs.svh"
module sync_serial_receive_framing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, go = 1'b0, msb = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, dma_size;
  logic [2:0] hsize = 3'h2;
  logic tk = 1'b0, tstart = 1'b0, rk, rf, rd, fs_out, fs_oe, tx_sel;
  wire logic rf_line = fs_oe ? fs_out : rf;
  int fail_count = 0, samples_checked = 0;
  always #12.5 hclk = ~hclk;
  codec_model i_codec (.go(go), .value(8'hC6), .high_first(msb), .rk(rk), .rf(rf), .rd(rd));
  sync_serial_receive_framing i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .receive_clock_pin(rk),
    .receive_frame_sync_pin_in(rf_line), .receive_frame_sync_pin_out(fs_out),
    .receive_frame_sync_pin_oe(fs_oe), .rx_data_pin(rd), .transmit_clock_pin(tk),
    .transmit_frame_sync_pin(1'b0), .transmit_data_pin(1'b0), .transmit_start(tstart),
    .transmit_clock_selected(tx_sel), .dma_transfer_size(dma_size));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) fail_count++;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) fail_count++;
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdv(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rdv
  task automatic s_registers;
    logic [31:0] q;
    rdv(`OFS_RX_CLOCK_MODE, q); check(q, 32'h0);
    rdv(`OFS_RX_FRAME_MODE, q); check(q, 32'h0);
    rdv(`OFS_TX_CLOCK_MODE, q); check(q, 32'h0);
    wr(`OFS_TX_CLOCK_MODE, 32'h0302_0102);
    rdv(`OFS_TX_CLOCK_MODE, q); check(q, 32'h0302_0102);
    wr(8'h08, 32'h1234_5678);
    rdv(8'h08, q); check(q, 32'h0);
  endtask : s_registers
  task automatic s_dma;
    logic [4:0] len [4] = '{5'h07, 5'h08, 5'h0F, 5'h10};
    logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_RX_FRAME_MODE, {27'h0, len[i]});
      repeat (3) @(posedge hclk);
      check({30'h0, dma_size}, {30'h0, sz[i]});
    end
  endtask : s_dma
  task automatic s_tx_clock;
    // divider left at zero, receive clock standing low, so only the pin code may follow
    logic exp [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    tk <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_TX_CLOCK_MODE, i);
      repeat (6) @(posedge hclk);
      check({31'h0, tx_sel}, {31'h0, exp[i]});
    end
    tk <= 1'b0;
  endtask : s_tx_clock
  task automatic s_receive(input logic first_high);
    logic [31:0] q;
    msb <= first_high;
    wr(`OFS_RX_FRAME_MODE, {24'h0, first_high, 7'h07});
    wr(`OFS_RX_CLOCK_MODE, 32'h0000_0402);
    wr(`OFS_CONTROL, 32'h1);
    go <= 1'b1;
    repeat (240) @(posedge hclk);
    go <= 1'b0;
    rdv(`OFS_STATUS, q); check({31'h0, q[`STS_RX_READY]}, 32'h1);
    rdv(`OFS_RX_HOLDING, q); check(q, 32'h0000_00C6);
    wr(`OFS_CONTROL, 32'h2);
  endtask : s_receive
  task automatic s_tx_start;
    // start with the transmitter, one delay clock: the lead-in bit becomes sync data
    logic [31:0] q;
    msb <= 1'b0;
    wr(`OFS_RX_FRAME_MODE, 32'h0001_0007);
    wr(`OFS_RX_CLOCK_MODE, 32'h0001_0102);
    wr(`OFS_CONTROL, 32'h1);
    repeat (2) @(posedge hclk);
    tstart <= 1'b1;
    @(posedge hclk);
    tstart <= 1'b0;
    go <= 1'b1;
    repeat (240) @(posedge hclk);
    go <= 1'b0;
    rdv(`OFS_STATUS, q); check({31'h0, q[`STS_RX_READY]}, 32'h1);
    rdv(`OFS_RX_HOLDING, q); check(q, 32'h0000_00C6);
    rdv(`OFS_RX_SYNC_HOLDING, q); check(q, 32'h0000_0001);
    wr(`OFS_CONTROL, 32'h2);
  endtask : s_tx_start
  task automatic s_shape;
    int n, w, p;
    wr(`OFS_CLOCK_MODE, 32'h4);
    wr(`OFS_RX_FRAME_MODE, 32'h0020_0007);
    wr(`OFS_RX_CLOCK_MODE, 32'h0100_0000);
    wr(`OFS_CONTROL, 32'h1);
    n = 0;
    do begin @(posedge hclk); n++; end while (fs_out !== 1'b1 && n < 400);
    w = 0;
    while (fs_out === 1'b1 && w < 400) begin @(posedge hclk); w++; end
    p = w;
    while (fs_out !== 1'b1 && p < 400) begin @(posedge hclk); p++; end
    check({31'h0, fs_oe}, 32'h1);
    check(32'(w), 32'd8);
    check(32'(p), 32'd32);
    wr(`OFS_RX_FRAME_MODE, 32'h0000_0007);
    repeat (3) @(posedge hclk);
    check({31'h0, fs_oe}, 32'h0);
    wr(`OFS_CONTROL, 32'h2);
  endtask : s_shape
  task automatic print_verdict;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_registers();
    s_dma();
    s_tx_clock();
    s_receive(1'b1);
    s_receive(1'b0);
    s_tx_start();
    s_shape();
    print_verdict();
  end
  // the whole sequence needs some 23 us; a hang is cut well past that
  initial begin
    #500us;
    fail_count++;
    print_verdict();
  end
endmodule : sync_serial_receive_framing_test
`default_nettype wire
